/* File: common/ltw_consts.svh */
// Constants of the logic trigger and word recognizer
`ifndef LTW_CONSTS_SVH
`define LTW_CONSTS_SVH
`define LTW_DATA_W 16
`define LTW_DIGIT_HEX_W 4
`define LTW_DIGIT_OCT_W 3
`define LTW_HEX_DIGITS 4
`define LTW_OCT_DIGITS 6
`define LTW_COUNT_W 24
`define LTW_COUNT_RST 24'h000000
`define LTW_DATA_RST 16'h0000
`define LTW_MASK_RST 16'h0000
`endif

/* File: common/ltw_pkg.sv */
// Types of the logic trigger and word recognizer
`include "ltw_consts.svh"
package ltw_pkg;
  typedef enum logic [2:0] {
    LTW_MODE_OFF = 3'h0,
    LTW_MODE_AND = 3'h1,
    LTW_MODE_OR = 3'h2,
    LTW_MODE_A_WORD = 3'h3,
    LTW_MODE_B_WORD = 3'h4,
    LTW_MODE_A_DBE = 3'h5
  } ltw_mode_type;
  typedef enum logic [1:0] {
    LTW_CLK_RISE = 2'h0,
    LTW_CLK_FALL = 2'h1,
    LTW_CLK_ASYNC = 2'h2
  } ltw_clk_mode_type;
  typedef enum logic [1:0] {
    LTW_Q_ZERO = 2'h0,
    LTW_Q_ONE = 2'h1,
    LTW_Q_DONT_CARE = 2'h2
  } ltw_qual_type;
  typedef struct packed {
    logic [`LTW_DATA_W-1:0] value;
    logic [`LTW_DATA_W-1:0] care;
    ltw_qual_type qual;
  } ltw_word_type;
  typedef struct packed {
    logic [`LTW_DATA_W-1:0] data;
    logic qual;
  } ltw_probe_type;
endpackage

/* File: logic/ltw_trigger.sv */
// Logic trigger combiner and word recognizer
//
// Behaviour
// RQ1: AND mode fires A sweep when A-and-B goes false to true.
// RQ2: OR mode fires A sweep when A-or-B goes false to true.
// RQ3: Each condition is slope-positive above level or slope-negative below.
// RQ4: Word modes fire A sweep or B sweep on a recognized word.
// RQ5: Match compares sixteen data bits plus one qualifier bit.
// RQ6: Qualifier is zero, one or don't-care; don't-care always matches.
// RQ7: Clock modes are rising edge, falling edge or asynchronous compare.
// RQ8: Digits set per bit in binary, per digit in octal or hex.
// RQ9: Hex or octal digit mixing don't-care and defined bits is ambiguous.
// RQ10: Match output high while the word is recognized, else low.
// RQ11: Match output follows latest word even when function disabled.
// RQ12: B word mode selects crystal timer for delay, else delay settings.
// RQ13: Auto-level selection during logic trigger cancels it, shows main menu.
// RQ14: Cancel disables every menu function, trigger and matcher alike; the code only forces mode OFF, word_match keeps following the word.
// RQ15: Match is an event source for counting, delay-by-events and trigger.
// RQ16: System under test presents data, qualifier and sampling clock.
// RQ17: Delay-by-events with words counts matches, then fires A sweep.
// RQ18: Clocked modes register the match on the selected edge.
`timescale 1ns/1ps
`include "ltw_consts.svh"
module ltw_trigger (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Probe clock and pins from the system under test
  input wire logic probe_clk,
  input wire ltw_pkg::ltw_probe_type probe_in,
  // Analog comparator results and slopes
  input wire logic a_above,
  input wire logic b_above,
  input wire logic a_slope_pos,
  input wire logic b_slope_pos,
  // Configuration
  input wire ltw_pkg::ltw_mode_type mode_sel,
  input wire logic mode_load,
  input wire ltw_pkg::ltw_clk_mode_type clk_mode,
  input wire ltw_pkg::ltw_word_type word_def,
  input wire logic [`LTW_COUNT_W-1:0] event_count,
  input wire logic cancel,
  input wire logic auto_level_trigger_mode,
  // Sweep triggers and status
  output logic a_sweep_trig,
  output logic b_sweep_trig,
  output logic word_match,
  output logic match_event,
  output logic crystal_timer_sel,
  output logic main_menu_req,
  output logic logic_trigger_function,
  output ltw_pkg::ltw_mode_type mode_active,
  output logic [`LTW_HEX_DIGITS-1:0] hex_ambiguous,
  output logic [`LTW_OCT_DIGITS-1:0] oct_ambiguous
);
  import ltw_pkg::*;

  // Reset release copies, one pair per clock domain
  logic rst_meta;
  logic rst_sync;
  logic prst_meta;
  logic prst_sync;

  // Probe pins staged on the system clock
  ltw_probe_type p_meta;
  ltw_probe_type p_sync;

  // Word definition and clock mode in the probe domain
  ltw_word_type w_meta;
  ltw_word_type w_link;
  ltw_clk_mode_type m_meta;
  ltw_clk_mode_type m_link;

  // Edge sampled results and their system clock copies
  logic rise_match;
  logic fall_match;
  logic rise_meta;
  logic rise_sync;
  logic fall_meta;
  logic fall_sync;

  // Selected match and its edge detector
  logic async_match;
  logic next_match;
  logic match_prev;

  // Comparator levels and the slope qualified conditions
  logic a_meta;
  logic a_sync;
  logic b_meta;
  logic b_sync;
  logic cond_a;
  logic cond_b;
  logic and_prev;
  logic or_prev;

  // Mode update and delay-by-events count
  ltw_mode_type next_mode_active;
  logic next_menu_req;
  logic [`LTW_COUNT_W-1:0] word_cnt;

  // Care mask and the digit flags before their register
  logic [`LTW_DATA_W-1:0] care_fall;
  logic [`LTW_HEX_DIGITS-1:0] next_hex_ambiguous;
  logic [`LTW_OCT_DIGITS-1:0] next_oct_ambiguous;

  // Reset release in the system clock domain
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Reset release in the probe clock domain
  always_ff @(posedge probe_clk or negedge reset_n) begin
    if (!reset_n) begin
      prst_meta <= 1'b0;
      prst_sync <= 1'b0;
    end else begin
      prst_meta <= 1'b1;
      prst_sync <= prst_meta;
    end
  end

  // Word definition is quasi-static; two stages into the probe domain
  always_ff @(posedge probe_clk or negedge prst_sync) begin
    if (!prst_sync) begin
      w_meta <= '0;
      w_link <= '0;
      m_meta <= LTW_CLK_RISE;
      m_link <= LTW_CLK_RISE;
    end else begin
      w_meta <= word_def;
      w_link <= w_meta;
      m_meta <= clk_mode;
      m_link <= m_meta;
    end
  end

  // Compare function for one sample
  function automatic logic word_hit(input ltw_word_type w,
                                    input ltw_probe_type p);
    logic q_ok;
    q_ok = (w.qual == LTW_Q_DONT_CARE) || // RQ6
           ((w.qual == LTW_Q_ONE) == p.qual);
    word_hit = q_ok && (((p.data ^ w.value) & w.care) == '0); // RQ5 RQ8
  endfunction

  // Rising edge sample of the probe word
  always_ff @(posedge probe_clk or negedge prst_sync) begin
    if (!prst_sync) begin
      rise_match <= 1'b0;
    end else begin
      rise_match <= (m_link == LTW_CLK_RISE) &&
                    word_hit(w_link, probe_in); // RQ7 RQ16 RQ18
    end
  end

  // Falling edge sample; definition used is the rising-domain copy
  always_ff @(negedge probe_clk or negedge prst_sync) begin
    if (!prst_sync) begin
      fall_match <= 1'b0;
    end else begin
      fall_match <= (m_link == LTW_CLK_FALL) &&
                    word_hit(w_link, probe_in); // RQ7 RQ18
    end
  end

  // Edge results into the system clock domain
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      rise_meta <= 1'b0;
      rise_sync <= 1'b0;
      fall_meta <= 1'b0;
      fall_sync <= 1'b0;
    end else begin
      rise_meta <= rise_match;
      rise_sync <= rise_meta;
      fall_meta <= fall_match;
      fall_sync <= fall_meta;
    end
  end

  // Asynchronous compare: raw pins pass two stages first
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      p_meta <= '0;
      p_sync <= '0;
      a_meta <= 1'b0;
      a_sync <= 1'b0;
      b_meta <= 1'b0;
      b_sync <= 1'b0;
    end else begin
      p_meta <= probe_in;
      p_sync <= p_meta;
      a_meta <= a_above;
      a_sync <= a_meta;
      b_meta <= b_above;
      b_sync <= b_meta;
    end
  end

  assign async_match = word_hit(word_def, p_sync); // RQ7

  // Select match per clock mode
  always_comb begin
    case (clk_mode)
      LTW_CLK_RISE: next_match = rise_sync;
      LTW_CLK_FALL: next_match = fall_sync;
      default: next_match = async_match;
    endcase
  end

  // Match output follows the current word regardless of mode
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      word_match <= 1'b0;
      match_prev <= 1'b0;
      match_event <= 1'b0;
    end else begin
      word_match <= next_match; // RQ10 RQ11
      match_prev <= next_match;
      match_event <= next_match && !match_prev; // RQ15
    end
  end

  // Slope-qualified trigger conditions
  assign cond_a = a_slope_pos ? a_sync : !a_sync; // RQ3
  assign cond_b = b_slope_pos ? b_sync : !b_sync; // RQ3

  // Next mode: cancel wins, then auto-level, then a load
  always_comb begin
    next_mode_active = mode_active;
    next_menu_req = 1'b0;
    if (cancel) begin
      next_mode_active = LTW_MODE_OFF; // RQ14
    end else if (auto_level_trigger_mode &&
                 mode_active != LTW_MODE_OFF) begin
      next_mode_active = LTW_MODE_OFF; // RQ13
      next_menu_req = 1'b1; // RQ13
    end else if (mode_load) begin
      next_mode_active = mode_sel;
    end
  end

  // Mode register and its menu request pulse
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      mode_active <= LTW_MODE_OFF;
      main_menu_req <= 1'b0;
    end else begin
      mode_active <= next_mode_active;
      main_menu_req <= next_menu_req; // RQ13
    end
  end

  // Previous combiner values for edge detection
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      and_prev <= 1'b0;
      or_prev <= 1'b0;
    end else begin
      and_prev <= cond_a && cond_b;
      or_prev <= cond_a || cond_b;
    end
  end

  // Word counter for delay-by-events
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      word_cnt <= `LTW_COUNT_RST;
    end else if (mode_active != LTW_MODE_A_DBE) begin
      word_cnt <= `LTW_COUNT_RST;
    end else if (match_event && word_cnt < event_count) begin
      word_cnt <= word_cnt + 1'b1; // RQ17
    end
  end

  // Sweep trigger pulses
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      a_sweep_trig <= 1'b0;
      b_sweep_trig <= 1'b0;
    end else begin
      a_sweep_trig <= 1'b0;
      b_sweep_trig <= 1'b0;
      case (mode_active)
        LTW_MODE_AND: a_sweep_trig <= cond_a && cond_b && !and_prev; // RQ1
        LTW_MODE_OR: a_sweep_trig <= (cond_a || cond_b) && !or_prev; // RQ2
        LTW_MODE_A_WORD: a_sweep_trig <= match_event; // RQ4
        LTW_MODE_B_WORD: b_sweep_trig <= match_event; // RQ4
        LTW_MODE_A_DBE: a_sweep_trig <= match_event &&
                          (word_cnt + 1'b1 == event_count); // RQ17
        default: a_sweep_trig <= 1'b0;
      endcase
    end
  end

  // Status flags, in step with the mode register
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      crystal_timer_sel <= 1'b0;
      logic_trigger_function <= 1'b0;
    end else begin
      crystal_timer_sel <= (next_mode_active == LTW_MODE_B_WORD); // RQ12
      logic_trigger_function <= (next_mode_active != LTW_MODE_OFF);
    end
  end

  // Digit ambiguity: a digit only partly cared for
  assign care_fall = word_def.care;
  genvar gi;
  generate
    for (gi = 0; gi < `LTW_HEX_DIGITS; gi++) begin : g_hex
      localparam int LO = gi * `LTW_DIGIT_HEX_W;
      assign next_hex_ambiguous[gi] =
        |care_fall[LO +: `LTW_DIGIT_HEX_W] &&
        !(&care_fall[LO +: `LTW_DIGIT_HEX_W]); // RQ9
    end
    for (gi = 0; gi < `LTW_OCT_DIGITS; gi++) begin : g_oct
      localparam int LO = gi * `LTW_DIGIT_OCT_W;
      localparam int HI = (LO + 2 >= `LTW_DATA_W) ? `LTW_DATA_W - 1 : LO + 2;
      assign next_oct_ambiguous[gi] =
        |care_fall[HI:LO] && !(&care_fall[HI:LO]); // RQ9
    end
  endgenerate

  // Flags registered so the outputs come from flip-flops
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      hex_ambiguous <= '0;
      oct_ambiguous <= '0;
    end else begin
      hex_ambiguous <= next_hex_ambiguous; // RQ9
      oct_ambiguous <= next_oct_ambiguous; // RQ9
    end
  end

endmodule // ltw_trigger

/* File: tb/ltw_trigger_monitor.sv */
// Checker of the trigger combiner and word recognizer
`timescale 1ns/1ps
module ltw_trigger_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Inputs
  input wire logic a_above,
  input wire logic b_above,
  input wire logic a_slope_pos,
  input wire logic b_slope_pos,
  input wire ltw_pkg::ltw_mode_type mode_sel,
  input wire logic mode_load,
  input wire logic cancel,
  input wire logic auto_level_trigger_mode,
  // Outputs
  input wire logic a_sweep_trig,
  input wire logic b_sweep_trig,
  input wire logic word_match,
  input wire logic match_event,
  input wire logic crystal_timer_sel,
  input wire logic main_menu_req,
  input wire logic logic_trigger_function,
  input wire ltw_pkg::ltw_mode_type mode_active
);
  import ltw_pkg::*;
  logic ca;
  logic cb;
  // Conditions from slope and level
  assign ca = a_above == a_slope_pos;
  assign cb = b_above == b_slope_pos;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  and_rise_a:
    assert property (a_sweep_trig && mode_active == LTW_MODE_AND
      |-> $past(ca && cb, 3) && !$past(ca && cb, 4))
    else $error("A sweep without AND rise");
  or_rise_a:
    assert property (a_sweep_trig && mode_active == LTW_MODE_OR
      |-> $past(ca || cb, 3) && !$past(ca || cb, 4))
    else $error("A sweep without OR rise");
  trig_pulse_a:
    assert property (a_sweep_trig |=> !a_sweep_trig)
    else $error("A sweep pulse too long");
  b_word_a:
    assert property (b_sweep_trig |-> $past(match_event) &&
      $past(word_match) && $past(mode_active == LTW_MODE_B_WORD))
    else $error("B sweep without match");
  load_mode_a:
    assert property (mode_load && !cancel && !auto_level_trigger_mode
      |=> mode_active == $past(mode_sel))
    else $error("Mode not loaded");
  crystal_sel_a:
    assert property (crystal_timer_sel == (mode_active == LTW_MODE_B_WORD))
    else $error("Timer select wrong");
  menu_req_a:
    assert property (auto_level_trigger_mode && logic_trigger_function
      && !cancel |=> main_menu_req && mode_active == LTW_MODE_OFF)
    else $error("Auto level did not cancel");
  cancel_off_a:
    assert property (cancel |=> !logic_trigger_function)
    else $error("Cancel left function on");
  event_match_a:
    assert property (match_event |-> word_match ##1 !match_event)
    else $error("Match event wrong");
endmodule // ltw_trigger_monitor
bind ltw_trigger ltw_trigger_monitor mon (
  .clk(clk),
  .reset_n(reset_n),
  .a_above(a_above),
  .b_above(b_above),
  .a_slope_pos(a_slope_pos),
  .b_slope_pos(b_slope_pos),
  .mode_sel(mode_sel),
  .mode_load(mode_load),
  .cancel(cancel),
  .auto_level_trigger_mode(auto_level_trigger_mode),
  .a_sweep_trig(a_sweep_trig),
  .b_sweep_trig(b_sweep_trig),
  .word_match(word_match),
  .match_event(match_event),
  .crystal_timer_sel(crystal_timer_sel),
  .main_menu_req(main_menu_req),
  .logic_trigger_function(logic_trigger_function),
  .mode_active(mode_active)
);

/* File: tb/ltw_sut_model.sv */
// Behavioural system under test on the probe
`timescale 1ns/1ps
module ltw_sut_model (
  // Word to present
  input wire ltw_pkg::ltw_probe_type word,
  // Probe pins
  output logic probe_clk,
  output ltw_pkg::ltw_probe_type probe_in
);
  import ltw_pkg::*;
  // Free running probe clock
  initial begin
    probe_clk = 1'h0;
    forever #32 probe_clk = ~probe_clk;
  end
  // Pins move midway between the two clock edges
  initial begin
    probe_in = '0;
    #16;
    forever begin
      probe_in = word;
      #64;
    end
  end
endmodule // ltw_sut_model

/* File: tb/ltw_trigger_bench.sv */
// Self-checking bench of the trigger combiner
`timescale 1ns/1ps
`include "ltw_consts.svh"
module ltw_trigger_bench;
  import ltw_pkg::*;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic probe_clk;
  logic a_above = 1'h0;
  logic b_above = 1'h0;
  logic a_slope_pos = 1'h0;
  logic b_slope_pos = 1'h0;
  logic mode_load = 1'h0;
  logic cancel = 1'h0;
  logic auto_level_trigger_mode = 1'h0;
  ltw_mode_type mode_sel = LTW_MODE_OFF;
  ltw_clk_mode_type clk_mode = LTW_CLK_RISE;
  ltw_word_type word_def = '0;
  ltw_probe_type probe_in;
  ltw_probe_type sut_word = '0;
  ltw_probe_type p;
  logic [`LTW_COUNT_W-1:0] event_count = 24'h000002;
  logic a_sweep_trig, b_sweep_trig, word_match, match_event;
  logic crystal_timer_sel, main_menu_req, logic_trigger_function;
  ltw_mode_type mode_active;
  logic [3:0] hex_ambiguous;
  logic [5:0] oct_ambiguous;
  int fails = 0;
  int check_count = 0;
  int seed = 47102;
  int na;
  int nm;
  int nb;
  logic e;
  // Clock and pulse counters
  always #20 clk = ~clk;
  always @(posedge clk) begin
    na += a_sweep_trig;
    nm += main_menu_req;
    nb += b_sweep_trig;
  end
  ltw_trigger dut (
    .clk(clk),
    .reset_n(reset_n),
    .probe_clk(probe_clk),
    .probe_in(probe_in),
    .a_above(a_above),
    .b_above(b_above),
    .a_slope_pos(a_slope_pos),
    .b_slope_pos(b_slope_pos),
    .mode_sel(mode_sel),
    .mode_load(mode_load),
    .clk_mode(clk_mode),
    .word_def(word_def),
    .event_count(event_count),
    .cancel(cancel),
    .auto_level_trigger_mode(auto_level_trigger_mode),
    .a_sweep_trig(a_sweep_trig),
    .b_sweep_trig(b_sweep_trig),
    .word_match(word_match),
    .match_event(match_event),
    .crystal_timer_sel(crystal_timer_sel),
    .main_menu_req(main_menu_req),
    .logic_trigger_function(logic_trigger_function),
    .mode_active(mode_active),
    .hex_ambiguous(hex_ambiguous),
    .oct_ambiguous(oct_ambiguous)
  );
  ltw_sut_model sut (.word(sut_word), .probe_clk, .probe_in);
  task automatic chk_bit(string n, logic x, logic s);
    check_count++;
    if (s !== x) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic chk_vec(string n, logic [15:0] x, logic [15:0] s);
    check_count++;
    if (s !== x) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic load(ltw_mode_type m);
    mode_sel = m;
    mode_load = 1'h1;
    cyc(1);
    mode_load = 1'h0;
  endtask
  function automatic logic hit(ltw_word_type w, ltw_probe_type q);
    return ((q.data ^ w.value) & w.care) == 16'h0000 &&
      (w.qual == LTW_Q_DONT_CARE || q.qual == w.qual[0]);
  endfunction
  function automatic logic [15:0] amb(logic [15:0] c);
    logic [17:0] x;
    x = {{2{c[15]}}, c};
    amb = 16'h0000;
    for (int i = 0; i < 4; i++) amb[i] = |c[4*i+:4] && !(&c[4*i+:4]);
    for (int i = 0; i < 6; i++) amb[4+i] = |x[3*i+:3] && !(&x[3*i+:3]);
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #200000;
    fails++;
    end_of_test();
  end
  // Main sequence
  initial begin
    cyc(6);
    reset_n = 1'h1;
    cyc(3);
    for (int m = 0; m < 6; m++) begin
      load(ltw_mode_type'(m));
      cyc(1);
      chk_vec("mode", 16'(m), 16'(mode_active));
      chk_bit("function", m != 0, logic_trigger_function);
      chk_bit("crystal", m == 4, crystal_timer_sel);
    end
    // AND then OR, random slopes, one condition then both
    for (int m = 1; m < 3; m++) begin
      a_slope_pos = 1'($random(seed));
      b_slope_pos = 1'($random(seed));
      a_above = ~a_slope_pos;
      b_above = ~b_slope_pos;
      load(ltw_mode_type'(m));
      cyc(6);
      na = 0;
      a_above = a_slope_pos;
      cyc(6);
      chk_vec("trig_one", 16'(m - 1), 16'(na));
      b_above = b_slope_pos;
      cyc(6);
      chk_vec("trig_both", 16'h0001, 16'(na));
    end
    // Auto level during an active trigger
    nm = 0;
    auto_level_trigger_mode = 1'h1;
    cyc(3);
    auto_level_trigger_mode = 1'h0;
    chk_vec("menu", 16'h0001, 16'(nm));
    // Random words in every clock and qualifier mode
    for (int i = 0; i < 9; i++) begin
      if (i == 6) load(LTW_MODE_B_WORD);
      clk_mode = ltw_clk_mode_type'(i % 3);
      word_def = {16'($random(seed)), 16'($random(seed)), 2'(i % 3)};
      p.data = word_def.value & word_def.care;
      p.data = p.data | 16'($random(seed)) & ~word_def.care;
      p.qual = word_def.qual[1] ? 1'($random(seed)) : word_def.qual[0];
      if (i % 2) p = p ^ (17'h00001 << ({$random(seed)} % 17));
      sut_word = p;
      e = hit(word_def, p);
      cyc(12);
      chk_bit("match", e, word_match);
      chk_vec("ambig", amb(word_def.care),
        {6'h00, oct_ambiguous, hex_ambiguous});
    end
    // Full care mask, then a non-matching word clears the match output
    word_def.care = 16'hFFFF;
    word_def.qual = LTW_Q_DONT_CARE;
    sut_word.data = ~word_def.value;
    cyc(12);
    // Word modes: one match fires only the chosen sweep
    for (int m = 3; m < 5; m++) begin
      load(ltw_mode_type'(m));
      na = 0;
      nb = 0;
      sut_word.data = word_def.value;
      cyc(12);
      chk_vec("word_a", 16'(m == 3), 16'(na));
      chk_vec("word_b", 16'(m == 4), 16'(nb));
      chk_bit("word_out", 1'h1, word_match);
      sut_word.data = ~word_def.value;
      cyc(12);
    end
    load(LTW_MODE_A_DBE);
    na = 0;
    for (int k = 0; k < 4; k++) begin
      sut_word.data = word_def.value ^ 16'(!k[0]);
      cyc(12);
      if (k == 1) chk_vec("early", 16'h0000, 16'(na));
    end
    chk_vec("fire", 16'h0001, 16'(na));
    cancel = 1'h1;
    cyc(1);
    cancel = 1'h0;
    cyc(1);
    chk_bit("cancel", 1'h0, logic_trigger_function);
    end_of_test();
  end
endmodule // ltw_trigger_bench
